// ==== rtl/mat_pkg.sv ====
// constants, carriers and helpers of the moving-average trip block
// assumes 40 MHz system clock and IEEE754 single samples from upstream
package mat_pkg;
  // **********************************************************************
  // sizes and counts
  // **********************************************************************
  localparam int NCH = 8;
  localparam int MEM_D = 1024;
  localparam int FRAC = 16;
  localparam int BLOCK_LEN = 1000;
  localparam logic [9:0] BLK_LAST = 10'h3E7;
  localparam logic [10:0] TRIG_WIN_LEN = 11'h3E8;
  localparam logic [10:0] MAX_LEN = 11'h400;
  localparam int VEC_HIGH = 0;
  localparam int VEC_MED = 8;
  localparam int VEC_LOW = 16;
  localparam logic [23:0] VEC_RST = 24'h000000;
  localparam int NROUTE = 5;
  localparam logic [31:0] CNT_RST = 32'h00000000;

  // **********************************************************************
  // types
  // **********************************************************************
  typedef logic [31:0] mat_float_t;
  typedef logic signed [63:0] mat_fix_t;
  typedef mat_float_t [NCH-1:0] mat_lim_t;
  typedef mat_fix_t [NCH-1:0] mat_sums_t;
  typedef struct packed {
    mat_float_t [NCH-1:0] cur;
  } mat_samp_t;
  typedef struct packed {
    logic soft_rst;
    logic trig_mode;
    logic trip_en;
    logic [2:0] route;
    logic man_trig;
  } mat_ctrl_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_ACQ = 2'b10
  } mat_state_t;

  // float to signed fixed point with FRAC fraction bits, saturating
  function automatic mat_fix_t mat_float_to_fix(input mat_float_t f);
    logic [63:0] mag;
    int sh;
    mag = {40'h0000000000, 1'b1, f[22:0]};
    sh = int'(f[30:23]) - 150 + FRAC;
    if (f[30:23] == 8'h00)
      mag = 64'h0;
    // cap at 2^40 so limit*N*1000 and the window sums stay inside 64 bits
    else if (sh > 16)
      mag = 64'h000000FFFFFFFFFF;
    else if (sh >= 0)
      mag = mag << sh;
    else if (sh > -24)
      mag = mag >> (-sh);
    else
      mag = 64'h0;
    return f[31] ? -$signed(mag) : $signed(mag);
  endfunction : mat_float_to_fix
endpackage : mat_pkg

// ==== rtl/mat_buf2.sv ====
// two-entry sample buffer between upstream and the averaging core
// assumes both sides on clk_sys
`timescale 1ns/10ps
`default_nettype none
module mat_buf2 (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset, low
  input wire logic in_valid, // upstream word offered
  output logic in_ready, // room for a word
  input wire mat_pkg::mat_samp_t in_data, // upstream word
  output logic out_valid, // word held
  input wire logic out_ready, // drain side takes word
  output mat_pkg::mat_samp_t out_data // oldest word
);
  import mat_pkg::*;
  mat_samp_t ent_q [2];
  logic [1:0] cnt_q, cnt_d;
  logic rd_q, rd_d, rdy_q, rdy_d, push, pop;

  always_comb
  begin
    push = in_valid && rdy_q;
    pop = (cnt_q != 2'h0) && out_ready;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    rd_d = rd_q ^ pop;
    rdy_d = (cnt_d != 2'h2);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
    end
    if (push)
      ent_q[rd_q ^ cnt_q[0]] <= in_data;
  end

  assign in_ready = rdy_q;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = ent_q[rd_q];

  buf_full_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cnt_q == 2'h2) |-> !in_ready)
    else $error("buffer full but ready high");
endmodule : mat_buf2
`default_nettype wire

// ==== rtl/mat_win_avg.sv ====
// one moving-average window over eight channels with threshold compare
// assumes in_valid at most once per sample, fixed-point input
`timescale 1ns/10ps
`default_nettype none
module mat_win_avg #(
  parameter int SCALE = 1
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset, low
  input wire logic clr, // drop history and sums
  input wire logic in_valid, // new sample set
  input wire mat_pkg::mat_sums_t in_fix, // samples, fixed point
  input wire logic [10:0] win_len, // window length N
  input wire mat_pkg::mat_lim_t limit, // per channel limit, float
  output mat_pkg::mat_sums_t sum_o, // running window sums
  output logic [7:0] over_o // pulse: average above limit
);
  import mat_pkg::*;
  mat_fix_t mem [NCH][MEM_D];
  logic [9:0] ptr_q, ptr_d;
  logic [10:0] fill_q, fill_d, len;
  mat_sums_t sum_q, sum_d;
  logic [NCH-1:0] over_q, over_d;
  mat_fix_t old, lim;

  // sum > limit*N*SCALE avoids a divider and keeps full precision
  always_comb
  begin
    old = '0;
    lim = '0;
    len = (win_len == 11'h000) ? 11'h001 :
          ((win_len > MAX_LEN) ? MAX_LEN : win_len);
    ptr_d = ptr_q;
    fill_d = fill_q;
    sum_d = sum_q;
    over_d = '0;
    if (clr)
    begin
      ptr_d = '0;
      fill_d = '0;
      sum_d = '0;
    end
    else if (in_valid)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        old = (fill_q >= len) ? mem[c][ptr_q] : '0; // R20
        sum_d[c] = $signed(sum_q[c]) + $signed(in_fix[c]) - old;
        lim = mat_fix_t'(mat_float_to_fix(limit[c]) * mat_fix_t'(len)
              * SCALE);
        over_d[c] = $signed(sum_d[c]) > lim; // R20
      end
      ptr_d = ({1'b0, ptr_q} + 11'h001 >= len) ? 10'h000 :
              ptr_q + 10'h001;
      fill_d = (fill_q < len) ? fill_q + 11'h001 : fill_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ptr_q <= '0;
      fill_q <= '0;
      sum_q <= '0;
      over_q <= '0;
    end
    else
    begin
      ptr_q <= ptr_d;
      fill_q <= fill_d;
      sum_q <= sum_d;
      over_q <= over_d;
    end
    if (in_valid && !clr)
      for (int c = 0; c < NCH; c++)
        mem[c][ptr_q] <= in_fix[c];
  end

  assign sum_o = sum_q;
  assign over_o = over_q;
endmodule : mat_win_avg
`default_nettype wire

// ==== rtl/mat_trip_core.sv ====
// moving-average over-threshold detector and protection trip
// assumes upstream calibrated floats on clk_sys, config from local regs
// Contract
// R01: takes eight parallel calibrated current samples at 1 MHz.
// R02: three averages per channel: high, medium on 1 MHz, low on 1 kHz.
// R03: 24-bit over-threshold vector, one bit per channel and window.
// R04: a bit sets when average exceeds limit and stays set.
// R05: vector clears only through the soft reset control.
// R06: trip output is the OR of all vector bits.
// R07: host picks a free trip route before enabling trip output.
// R08: vector readable by host.
// R09: over-threshold flags produced continuously in continuous mode.
// R10: triggered mode uses only high and low windows, length 1000.
// R11: trigger comes from the shared line or a debug bit.
// R12: only the rising edge of a trigger acts.
// R13: at window end freeze accumulators and copy them out.
// R14: at window end store counts of 1 MHz and 1 kHz samples.
// R15: delay and acquisition times come from host registers.
// R16: soft reset bit clears vector and all accumulators.
// R17: mode bit zero continuous, one triggered.
// R18: trip enable bit and route codes 0 to 4 choose a line.
// R19: manual bit rising edge fires a trigger like the line.
// R20: average is sum of last N samples over N, compared.
// R21: 1 kHz stream is per-channel mean of 1000-sample blocks.
// R22: after trigger wait delay, acquire for time, then freeze.
`timescale 1ns/10ps
`default_nettype none
module mat_trip_core (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic rst_n, // synchronous reset, low
  input wire logic samp_valid, // upstream sample set valid
  output logic samp_ready, // buffer can take a set
  input wire mat_pkg::mat_samp_t samp_data, // eight float currents
  input wire logic trig_line, // shared trigger line, async
  input wire mat_pkg::mat_ctrl_t ctrl, // control and config bits
  input wire logic [31:0] win_len_high, // high window length
  input wire logic [31:0] win_len_medium, // medium window length
  input wire logic [31:0] win_len_low, // low window length
  input wire mat_pkg::mat_lim_t per_channel_limit_high, // float limits
  input wire mat_pkg::mat_lim_t per_channel_limit_medium, // float limits
  input wire mat_pkg::mat_lim_t per_channel_limit_low, // float limits
  input wire logic [31:0] delay_time, // trigger delay, cycles
  input wire logic [31:0] acq_time, // acquisition time, cycles
  output logic [23:0] over_vec, // sticky over-threshold vector
  output logic protection_trip_out, // trip, before routing
  output logic [4:0] trip_line_out, // routed trip lines
  output mat_pkg::mat_sums_t acc_fast, // frozen high sums
  output mat_pkg::mat_sums_t acc_slow, // frozen low sums
  output logic [31:0] cnt_fast, // 1 MHz samples in window
  output logic [31:0] cnt_slow, // 1 kHz samples in window
  output logic trig_busy // trigger sequence running
);
  import mat_pkg::*;

  // **********************************************************************
  // input buffer and conversion
  // **********************************************************************
  logic buf_valid, take;
  mat_samp_t buf_data;
  mat_sums_t fix_in;

  // holding soft reset stalls the drain, so upstream sees back-pressure
  mat_buf2 u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(samp_valid),
    .in_ready(samp_ready),
    .in_data(samp_data),
    .out_valid(buf_valid),
    .out_ready(!ctrl.soft_rst),
    .out_data(buf_data)
  );

  always_comb
  begin
    take = buf_valid && !ctrl.soft_rst; // R01
    for (int c = 0; c < NCH; c++)
      fix_in[c] = mat_float_to_fix(buf_data.cur[c]);
  end

  // **********************************************************************
  // trigger edge detection
  // **********************************************************************
  logic trg_s1_q, trg_s2_q, trg_s3_q, man_q, rise;
  logic trg_s1_d, trg_s2_d, trg_s3_d, man_d;

  always_comb
  begin
    trg_s1_d = trig_line;
    trg_s2_d = trg_s1_q;
    trg_s3_d = trg_s2_q;
    man_d = ctrl.man_trig;
    rise = (trg_s2_q && !trg_s3_q) || (ctrl.man_trig && !man_q); // R11 R12 R19
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_s3_q <= 1'b0;
      man_q <= 1'b0;
    end
    else
    begin
      trg_s1_q <= trg_s1_d;
      trg_s2_q <= trg_s2_d;
      trg_s3_q <= trg_s3_d;
      man_q <= man_d;
    end
  end

  // **********************************************************************
  // trigger sequencer
  // **********************************************************************
  mat_state_t st_q, st_d;
  logic [31:0] tcnt_q, tcnt_d, nf_q, nf_d, ns_q, ns_d;
  logic [31:0] cnt_fast_q, cnt_fast_d, cnt_slow_q, cnt_slow_d;
  mat_sums_t acc_fast_q, acc_fast_d, acc_slow_q, acc_slow_d;
  mat_sums_t sum_high, sum_med, sum_low;
  logic acq_start, acq_end, run, slow_v_q, busy_q, busy_d;

  always_comb
  begin
    st_d = st_q;
    tcnt_d = tcnt_q;
    nf_d = nf_q;
    ns_d = ns_q;
    cnt_fast_d = cnt_fast_q;
    cnt_slow_d = cnt_slow_q;
    acc_fast_d = acc_fast_q;
    acc_slow_d = acc_slow_q;
    acq_start = 1'b0;
    acq_end = 1'b0;
    case (st_q)
      ST_IDLE:
        if (ctrl.trig_mode && rise) // R17 R12
        begin
          st_d = ST_DELAY;
          tcnt_d = '0;
        end
      ST_DELAY:
        if (tcnt_q >= delay_time) // R15 R22
        begin
          st_d = ST_ACQ;
          tcnt_d = '0;
          nf_d = '0;
          ns_d = '0;
          acq_start = 1'b1;
        end
        else
          tcnt_d = tcnt_q + 32'h00000001;
      ST_ACQ:
      begin
        tcnt_d = tcnt_q + 32'h00000001;
        nf_d = nf_q + {31'h0, take};
        ns_d = ns_q + {31'h0, slow_v_q};
        if (tcnt_d >= acq_time) // R15 R22
        begin
          st_d = ST_IDLE;
          acq_end = 1'b1;
          acc_fast_d = sum_high; // R13
          acc_slow_d = sum_low; // R13
          cnt_fast_d = nf_d; // R14
          cnt_slow_d = ns_d; // R14
        end
      end
      default:
        st_d = ST_IDLE;
    endcase
    if (!ctrl.trig_mode || ctrl.soft_rst)
      st_d = ST_IDLE;
    // outside acquisition the windows hold still in triggered mode
    run = !ctrl.trig_mode || (st_q == ST_ACQ); // R09 R17
    busy_d = (st_d != ST_IDLE);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      tcnt_q <= CNT_RST;
      nf_q <= CNT_RST;
      ns_q <= CNT_RST;
      cnt_fast_q <= CNT_RST;
      cnt_slow_q <= CNT_RST;
      acc_fast_q <= '0;
      acc_slow_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      busy_q <= busy_d;
      tcnt_q <= tcnt_d;
      nf_q <= nf_d;
      ns_q <= ns_d;
      cnt_fast_q <= cnt_fast_d;
      cnt_slow_q <= cnt_slow_d;
      acc_fast_q <= acc_fast_d;
      acc_slow_q <= acc_slow_d;
    end
  end

  // **********************************************************************
  // 1 kHz decimation and the three windows
  // **********************************************************************
  mat_sums_t blk_q, blk_d, slow_q, slow_d;
  logic [9:0] bcnt_q, bcnt_d;
  logic slow_v_d, clr, fast_v;
  logic [10:0] len_h, len_m, len_l;

  always_comb
  begin
    clr = ctrl.soft_rst || acq_start; // R16
    fast_v = take && run;
    blk_d = blk_q;
    bcnt_d = bcnt_q;
    slow_d = slow_q;
    slow_v_d = 1'b0;
    if (clr)
    begin
      blk_d = '0;
      bcnt_d = '0;
    end
    else if (fast_v)
    begin
      // block sums stay scaled by 1000; the low limit is scaled to match
      for (int c = 0; c < NCH; c++)
        blk_d[c] = $signed(blk_q[c]) + $signed(fix_in[c]); // R21
      if (bcnt_q == BLK_LAST)
      begin
        slow_d = blk_d; // R21
        slow_v_d = 1'b1;
        blk_d = '0;
        bcnt_d = '0;
      end
      else
        bcnt_d = bcnt_q + 10'h001;
    end
    len_h = ctrl.trig_mode ? TRIG_WIN_LEN : 11'(win_len_high); // R10
    len_m = 11'(win_len_medium);
    len_l = ctrl.trig_mode ? TRIG_WIN_LEN : 11'(win_len_low); // R10
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      blk_q <= '0;
      bcnt_q <= '0;
      slow_q <= '0;
      slow_v_q <= 1'b0;
    end
    else
    begin
      blk_q <= blk_d;
      bcnt_q <= bcnt_d;
      slow_q <= slow_d;
      slow_v_q <= slow_v_d;
    end
  end

  logic [7:0] ov_h, ov_m, ov_l;

  mat_win_avg #(.SCALE(1)) u_high ( // R02
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(clr),
    .in_valid(fast_v),
    .in_fix(fix_in),
    .win_len(len_h),
    .limit(per_channel_limit_high),
    .sum_o(sum_high),
    .over_o(ov_h)
  );

  mat_win_avg #(.SCALE(1)) u_med ( // R02
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(clr),
    .in_valid(fast_v && !ctrl.trig_mode),
    .in_fix(fix_in),
    .win_len(len_m),
    .limit(per_channel_limit_medium),
    .sum_o(sum_med),
    .over_o(ov_m)
  );

  mat_win_avg #(.SCALE(BLOCK_LEN)) u_low ( // R02
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(clr),
    .in_valid(slow_v_q && run),
    .in_fix(slow_q),
    .win_len(len_l),
    .limit(per_channel_limit_low),
    .sum_o(sum_low),
    .over_o(ov_l)
  );

  // **********************************************************************
  // sticky vector and trip routing
  // **********************************************************************
  logic [23:0] vec_q, vec_d;
  logic trip_q, trip_d;
  logic [4:0] line_q, line_d;

  always_comb
  begin
    // a compare landing in the clear cycle survives; set wins
    vec_d = (ctrl.soft_rst ? VEC_RST : vec_q) | {ov_l, ov_m, ov_h}; // R03 R04 R05 R16
    trip_d = ctrl.trip_en && (|vec_q); // R06 R18
    for (int i = 0; i < NROUTE; i++)
      line_d[i] = trip_d && (ctrl.route == 3'(i)); // R18
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      vec_q <= VEC_RST;
      trip_q <= 1'b0;
      line_q <= '0;
    end
    else
    begin
      vec_q <= vec_d;
      trip_q <= trip_d;
      line_q <= line_d;
    end
  end

  assign over_vec = vec_q; // R08
  assign protection_trip_out = trip_q;
  assign trip_line_out = line_q;
  assign acc_fast = acc_fast_q;
  assign acc_slow = acc_slow_q;
  assign cnt_fast = cnt_fast_q;
  assign cnt_slow = cnt_slow_q;
  assign trig_busy = busy_q;

  // **********************************************************************
  // checks
  // **********************************************************************
  vec_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R04
    !ctrl.soft_rst |=> ((vec_q & $past(vec_q)) == $past(vec_q)))
    else $error("over bit dropped without soft reset");
  vec_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R05
    ctrl.soft_rst ##1 ctrl.soft_rst |=> (vec_q == VEC_RST))
    else $error("vector not cleared by soft reset");
  vec_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R03
    (ov_h[0] && !ctrl.soft_rst) |=> vec_q[VEC_HIGH])
    else $error("high compare did not set vector bit");
  trip_or_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R06
    ##1 (protection_trip_out == $past(ctrl.trip_en && (|vec_q))))
    else $error("trip is not the OR of the vector");
  route_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
    ##1 (trip_line_out == ($past(trip_d && ctrl.route < 3'h5) ?
      5'(5'h01 << $past(ctrl.route)) : 5'h00)))
    else $error("trip routed to wrong line");
  med_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    ctrl.trig_mode ##1 ctrl.trig_mode |-> (ov_m == 8'h00))
    else $error("medium window active in triggered mode");
  trig_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    (st_q == ST_IDLE && ctrl.trig_mode && !ctrl.soft_rst && !rise)
    |=> (st_q == ST_IDLE))
    else $error("trigger started without rising edge");
  freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    acq_end |=> (acc_fast == $past(sum_high) && acc_slow == $past(sum_low)))
    else $error("accumulators not frozen at window end");
  count_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
    acq_end |=> (cnt_fast == $past(nf_d) && cnt_slow == $past(ns_d)))
    else $error("sample counts not stored");
  delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R22
    (st_q == ST_DELAY && tcnt_q < delay_time && ctrl.trig_mode
     && !ctrl.soft_rst) |=> (st_q == ST_DELAY))
    else $error("acquisition began before delay elapsed");
endmodule : mat_trip_core
`default_nettype wire

// ==== bench/mat_src.sv ====
// upstream model: offers calibrated sample sets by valid and ready
// assumes every call starts just after a rising edge of clk_sys
`timescale 1ns/10ps
`default_nettype none
module mat_src (
  input wire logic clk_sys, // system clock
  input wire logic samp_ready, // block has room
  output logic samp_valid, // set offered
  output mat_pkg::mat_samp_t samp_data, // eight currents
  output logic hang // ready never came
);
  import mat_pkg::*;
  initial
  begin
    samp_valid = 1'b0;
    samp_data = '0;
    hang = 1'b0;
  end
  // released data shows the inverse so a stale word never looks good
  task automatic send(input mat_samp_t w, input int n, input int gap);
    int t;
    for (int i = 0; i < n; i++)
    begin
      samp_valid <= 1'b1;
      samp_data <= w;
      t = 0;
      do
      begin
        @(posedge clk_sys);
        t++;
      end
      while (samp_ready !== 1'b1 && t < 200);
      if (t >= 200)
        hang <= 1'b1;
      if (gap > 0)
      begin
        samp_valid <= 1'b0;
        samp_data <= ~w;
        repeat (gap) @(posedge clk_sys);
      end
    end
    samp_valid <= 1'b0;
    samp_data <= ~w;
  endtask : send
endmodule : mat_src
`default_nettype wire

// ==== bench/mat_trip_core_tb.sv ====
// self-checking bench of the moving-average trip block
// assumes the upstream model mat_src and the package mat_pkg
`timescale 1ns/10ps
`default_nettype none
module mat_trip_core_tb;
  import mat_pkg::*;
  localparam mat_float_t ONE = 32'h3F800000;
  localparam mat_float_t TWO = 32'h40000000;
  localparam mat_float_t BIG = 32'h7F000000;
  logic clk_sys = 1'b0;
  logic rst_n, samp_valid, samp_ready, trig_line;
  logic protection_trip_out, trig_busy, hang;
  mat_samp_t samp_data, w_a, w_b, w_z, w_t;
  mat_ctrl_t ctrl;
  mat_lim_t lim_h, lim_m, lim_l;
  mat_sums_t acc_fast, acc_slow;
  logic [31:0] n_h, n_m, n_l, delay_time, acq_time, cnt_fast, cnt_slow;
  logic [23:0] over_vec;
  logic [4:0] trip_line_out;
  int num_errors = 0;
  int total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  mat_src u_src (.clk_sys(clk_sys), .samp_ready(samp_ready),
    .samp_valid(samp_valid), .samp_data(samp_data), .hang(hang));
  mat_trip_core u_mat_trip_core (.clk_sys(clk_sys), .rst_n(rst_n),
    .samp_valid(samp_valid), .samp_ready(samp_ready),
    .samp_data(samp_data), .trig_line(trig_line), .ctrl(ctrl),
    .win_len_high(n_h), .win_len_medium(n_m), .win_len_low(n_l),
    .per_channel_limit_high(lim_h), .per_channel_limit_medium(lim_m),
    .per_channel_limit_low(lim_l), .delay_time(delay_time),
    .acq_time(acq_time), .over_vec(over_vec),
    .protection_trip_out(protection_trip_out),
    .trip_line_out(trip_line_out), .acc_fast(acc_fast),
    .acc_slow(acc_slow), .cnt_fast(cnt_fast), .cnt_slow(cnt_slow),
    .trig_busy(trig_busy));
  // ****************************************************************
  // compare, wait and closing tasks
  // ****************************************************************
  task automatic chk_v(input string nm, input logic [63:0] exp,
    input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_v
  task automatic chk_s(input string nm, input mat_sums_t exp,
    input mat_sums_t got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_s
  task automatic end_sim;
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic wait_busy(input logic lvl, input int lim);
    int t;
    t = 0;
    while (trig_busy !== lvl && t < lim)
    begin
      @(posedge clk_sys);
      t++;
    end
    if (trig_busy !== lvl)
    begin
      chk_v("trig_busy wait", 64'(lvl), 64'(trig_busy));
      end_sim();
    end
  endtask : wait_busy
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    rst_n = 1'b0;
    trig_line = 1'b0;
    ctrl = '0;
    n_h = 32'h00000004;
    n_m = 32'h00000004;
    n_l = 32'h00000001;
    delay_time = 32'h00000014;
    acq_time = 32'h0000012C;
    lim_h = {NCH{BIG}};
    lim_m = {NCH{BIG}};
    lim_l = {NCH{BIG}};
    lim_h[0] = ONE;
    lim_h[3] = ONE;
    lim_h[4] = ONE;
    lim_m[2] = ONE;
    lim_l[1] = ONE;
    w_z = '0;
    w_a = '0;
    w_a.cur[0] = TWO;
    w_a.cur[1] = TWO;
    w_a.cur[2] = TWO;
    w_a.cur[3] = ONE;
    w_a.cur[4] = 32'h40400000;
    w_b = w_a;
    w_b.cur[4] = '0;
    w_t = {NCH{32'h3FC00000}};
    tick(8);
    rst_n <= 1'b1;
    tick(2);
    chk_v("samp_ready", 64'h1, 64'(samp_ready));
    chk_v("over_vec", 64'h0, 64'(over_vec));
    // buffer: drain side stalls while soft reset is held
    ctrl.soft_rst <= 1'b1;
    fork
      u_src.send(w_z, 3, 0);
    join_none
    tick(10);
    chk_v("samp_ready full", 64'h0, 64'(samp_ready));
    chk_v("samp_valid held", 64'h1, 64'(samp_valid));
    ctrl.soft_rst <= 1'b0;
    tick(10);
    chk_v("samp_valid taken", 64'h0, 64'(samp_valid));
    chk_v("samp_ready empty", 64'h1, 64'(samp_ready));
    // continuous mode: spike under N, equal not over, sticky bits
    ctrl.trip_en <= 1'b1;
    u_src.send(w_a, 1, 0);
    tick(1);
    u_src.send(w_b, 3, 0);
    tick(8);
    chk_v("over_vec short", 64'h401, 64'(over_vec));
    chk_v("trip", 64'h1, 64'(protection_trip_out));
    tick(1);
    u_src.send(w_b, 996, 0);
    tick(12);
    chk_v("over_vec low", 64'h20401, 64'(over_vec));
    tick(1);
    u_src.send(w_z, 10, 0);
    tick(8);
    chk_v("over_vec sticky", 64'h20401, 64'(over_vec));
    for (int r = 0; r < 8; r++)
    begin
      ctrl.route <= 3'(r);
      tick(4);
      chk_v("trip_line_out", (r < NROUTE) ? 64'(1 << r) : 64'h0,
        64'(trip_line_out));
    end
    ctrl.trip_en <= 1'b0;
    tick(4);
    chk_v("trip off", 64'h0, 64'(protection_trip_out));
    ctrl.soft_rst <= 1'b1;
    tick(4);
    chk_v("over_vec clear", 64'h0, 64'(over_vec));
    ctrl.soft_rst <= 1'b0;
    tick(1);
    // triggered mode by the debug bit, then by the line
    ctrl.trig_mode <= 1'b1;
    tick(2);
    ctrl.man_trig <= 1'b1;
    wait_busy(1'b1, 5);
    tick(30);
    u_src.send(w_t, 5, 3);
    tick(200);
    chk_v("busy in acq", 64'h1, 64'(trig_busy));
    wait_busy(1'b0, 100);
    tick(2);
    chk_v("cnt_fast", 64'h5, 64'(cnt_fast));
    chk_v("cnt_slow", 64'h0, 64'(cnt_slow));
    chk_s("acc_fast", {NCH{64'h0000000000078000}}, acc_fast);
    chk_s("acc_slow", '0, acc_slow);
    chk_v("medium idle", 64'h0, 64'(over_vec[15:8]));
    tick(20);
    chk_v("level no retrig", 64'h0, 64'(trig_busy));
    ctrl.man_trig <= 1'b0;
    trig_line <= 1'b1;
    wait_busy(1'b1, 10);
    ctrl.trig_mode <= 1'b0;
    tick(4);
    chk_v("mode abort", 64'h0, 64'(trig_busy));
    chk_v("src hang", 64'h0, 64'(hang));
    end_sim();
  end
endmodule : mat_trip_core_tb
`default_nettype wire
